/* pcrfb_bridge.sv */
// Purpose: Rate bridge between a fast PHY datapath and a slower video core
// Assumes: PHY side runs on mclk; core clock arrives as a pin and is sampled
// Notes:   Holds the FIFO and the top module
//
// How it works
// [RQ1] The PHY datapath clock is faster than the recovered clock, so the core side is slower.
// [RQ2] The system PLL runs at no less than 150, 300 or 600 MHz for HD, 3G or 12G.
// [RQ3] The core side runs on a 148.5 MHz recovered clock, or 74.25 MHz for HD.
// [RQ4] The PHY supplies a half-rate recovered clock and a slower one at the core rate.
// [RQ5] A FIFO carries each direction between the fast PHY side and the slow core side.
// [RQ6] A received PHY word enters the FIFO only when its bit 38 qualifier is set.
// [RQ7] The transmit cadence strobe both pops the FIFO and drives the outgoing qualifier.
// [RQ8] Reads happen only when the FIFO is not empty and writes only when it is not full.
`timescale 1ns/1ns
`include "pcrfb_cfg.svh"

// ------------------------------------------------------------
// Synchronous FIFO
// ------------------------------------------------------------
module pcrfb_fifo #(
    parameter int WIDTH = `PCRFB_DATA_WIDTH,
    parameter int DEPTH = `PCRFB_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic wrValid,
    output logic wrReady,
    input wire logic [WIDTH-1:0] wrData,
    output logic rdValid,
    input wire logic rdReady,
    output logic [WIDTH-1:0] rdData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    logic doWr;
    logic doRd;

    // Refuse depths the pointer wrap cannot serve, at elaboration
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
        $error("pcrfb_fifo: DEPTH must be a power of two, at least 2");
    end

    // Honest flags; transfers only when allowed
    assign wrReady = (count_r != DEPTH[AW:0]);
    assign rdValid = (count_r != '0);
    assign doWr = wrValid && wrReady; // see [RQ8]
    assign doRd = rdReady && rdValid; // see [RQ8]
    assign rdData = mem[rdPtr_r];

    // Storage
    always_ff @(posedge mclk) begin
        if (doWr) begin
            mem[wrPtr_r] <= wrData;
        end
    end

    // Pointers and fill level
    always_ff @(posedge mclk) begin
        if (srst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doWr) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (doRd) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            if (doWr && !doRd) begin
                count_r <= count_r + 1'b1;
            end else if (doRd && !doWr) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// ------------------------------------------------------------
// Bridge top
// ------------------------------------------------------------
module pcrfb_bridge
    import pcrfb_pkg::*;
#(
    parameter int PHY_WIDTH = `PCRFB_PHY_WIDTH,
    parameter int DATA_WIDTH = `PCRFB_DATA_WIDTH,
    parameter int VALID_BIT = `PCRFB_VALID_BIT,
    parameter int DEPTH = `PCRFB_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic coreClk,
    input wire logic [PHY_WIDTH-1:0] rxPhyData,
    output logic [DATA_WIDTH-1:0] rxCoreData_r,
    output logic rxCoreValid_r,
    output logic rxOverflow_r,
    input wire logic [DATA_WIDTH-1:0] txCoreData,
    input wire logic txCoreValid,
    output logic txCoreReady_r,
    input wire logic txCadence,
    output logic [PHY_WIDTH-1:0] txPhyData_r,
    output logic txUnderrun_r
);
    logic [2:0] coreSync_r;
    logic coreLvl_r;
    logic coreRise;
    logic coreFall;
    logic rxWrReady;
    logic rxRdValid;
    logic [DATA_WIDTH-1:0] rxRdData;
    logic txWrReady;
    logic txRdValid;
    logic [DATA_WIDTH-1:0] txRdData;

    // Refuse layouts the word cannot hold, at elaboration
    if (VALID_BIT >= PHY_WIDTH || DATA_WIDTH > VALID_BIT) begin
        $error("pcrfb_bridge: qualifier bit must sit above data, inside the word");
    end

    // Core clock sampler; a level counts once stages two and three agree
    always_ff @(posedge mclk) begin
        if (srst) begin
            coreSync_r <= `PCRFB_SYNC_RST;
        end else begin
            coreSync_r <= {coreSync_r[1:0], coreClk};
        end
    end

    // Settled core clock level
    always_ff @(posedge mclk) begin
        if (srst) begin
            coreLvl_r <= 1'b0;
        end else if (coreSync_r[1] == coreSync_r[2]) begin
            coreLvl_r <= coreSync_r[2];
        end
    end

    // Core clock edges, whatever its rate (148.5 or 74.25 MHz class)
    assign coreRise = (coreSync_r[1] == coreSync_r[2]) && coreSync_r[2] && !coreLvl_r; // see [RQ3]
    assign coreFall = (coreSync_r[1] == coreSync_r[2]) && !coreSync_r[2] && coreLvl_r; // see [RQ3]

    // Receive FIFO, filled at PHY rate, drained at core rate
    pcrfb_fifo #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(DEPTH)
    ) rxFifo (
        .mclk(mclk),
        .srst(srst),
        .wrValid(rxPhyData[VALID_BIT]), // see [RQ6] [RQ5]
        .wrReady(rxWrReady),
        .wrData(rxPhyData[DATA_WIDTH-1:0]),
        .rdValid(rxRdValid),
        .rdReady(coreRise), // see [RQ5]
        .rdData(rxRdData)
    );

    // Core-side receive word, updated on each core clock rise
    always_ff @(posedge mclk) begin
        if (srst) begin
            rxCoreData_r <= '0;
            rxCoreValid_r <= 1'b0;
        end else if (coreRise) begin
            rxCoreData_r <= rxRdValid ? rxRdData : rxCoreData_r; // see [RQ8]
            rxCoreValid_r <= rxRdValid;
        end
    end

    // Sticky flag for a qualified word met by a full FIFO
    always_ff @(posedge mclk) begin
        if (srst) begin
            rxOverflow_r <= 1'b0;
        end else if (rxPhyData[VALID_BIT] && !rxWrReady) begin
            rxOverflow_r <= 1'b1;
        end
    end

    // Transmit FIFO, filled mid core period when core data is stable
    pcrfb_fifo #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(DEPTH)
    ) txFifo (
        .mclk(mclk),
        .srst(srst),
        .wrValid(coreFall && txCoreValid), // see [RQ5]
        .wrReady(txWrReady),
        .wrData(txCoreData),
        .rdValid(txRdValid),
        .rdReady(txCadence), // see [RQ7]
        .rdData(txRdData)
    );

    // Back-pressure toward the core
    always_ff @(posedge mclk) begin
        if (srst) begin
            txCoreReady_r <= 1'b0;
        end else begin
            txCoreReady_r <= txWrReady; // see [RQ8]
        end
    end

    // PHY transmit word; qualifier follows the cadence strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            txPhyData_r <= '0;
        end else begin
            txPhyData_r[VALID_BIT] <= txCadence; // see [RQ7]
            if (txCadence && txRdValid) begin
                txPhyData_r[DATA_WIDTH-1:0] <= txRdData; // see [RQ7] [RQ8]
            end
        end
    end

    // Sticky flag for a cadence strobe met by an empty FIFO
    always_ff @(posedge mclk) begin
        if (srst) begin
            txUnderrun_r <= 1'b0;
        end else if (txCadence && !txRdValid) begin
            txUnderrun_r <= 1'b1;
        end
    end
endmodule

/* pcrfb_bridge_checker.sv */
// Purpose: Port assertions on the rate bridge
// Assumes: One mclk domain, srst synchronous
// Notes:   Bound into pcrfb_bridge
`timescale 1ns/1ns
module pcrfb_bridge_checker #(
    parameter int VALID_BIT = 38
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [39:0] rxPhyData,
    input wire logic rxOverflow_r,
    input wire logic txCadence,
    input wire logic [39:0] txPhyData_r,
    input wire logic txUnderrun_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Outgoing qualifier follows the cadence strobe by one cycle
    cad_qual_a: assert property (txCadence |=> txPhyData_r[VALID_BIT])
        else $error("qualifier missing");
    cad_idle_a: assert property (!txCadence |=> !txPhyData_r[VALID_BIT])
        else $error("qualifier without strobe");
    data_hold_a: assert property (!txCadence |=> $stable(txPhyData_r[19:0]))
        else $error("tx data moved");
    pad_zero_a: assert property (txPhyData_r[37:20] == 18'h0 && !txPhyData_r[39])
        else $error("tx pad bits set");
    ovf_sticky_a: assert property (rxOverflow_r |=> rxOverflow_r)
        else $error("overflow cleared");
    ovf_cause_a: assert property ($rose(rxOverflow_r) |-> $past(rxPhyData[VALID_BIT]))
        else $error("overflow without word");
    und_sticky_a: assert property (txUnderrun_r |=> txUnderrun_r)
        else $error("underrun cleared");
    und_cause_a: assert property ($rose(txUnderrun_r) |-> $past(txCadence))
        else $error("underrun without strobe");
endmodule

bind pcrfb_bridge pcrfb_bridge_checker #(.VALID_BIT(VALID_BIT)) i_chk (.mclk(mclk),
    .srst(srst), .rxPhyData(rxPhyData), .rxOverflow_r(rxOverflow_r),
    .txCadence(txCadence), .txPhyData_r(txPhyData_r), .txUnderrun_r(txUnderrun_r));

/* pcrfb_cfg.svh */
// Purpose: Constants for the PHY to core rate bridge
// Assumes: Included by bare name from the package and the bridge
// Notes:   Definitions only
`ifndef PCRFB_CFG_SVH
`define PCRFB_CFG_SVH

// ------------------------------------------------------------
// Word layout
// ------------------------------------------------------------
`define PCRFB_PHY_WIDTH 40
`define PCRFB_DATA_WIDTH 20
`define PCRFB_VALID_BIT 38
`define PCRFB_FIFO_DEPTH 8

// ------------------------------------------------------------
// Clock rates in kHz
// ------------------------------------------------------------
`define PCRFB_MCLK_KHZ 100000
`define PCRFB_CORE_KHZ 148500
`define PCRFB_CORE_HD_KHZ 74250
`define PCRFB_PLL_HD_MIN_KHZ 150000
`define PCRFB_PLL_3G_MIN_KHZ 300000
`define PCRFB_PLL_12G_MIN_KHZ 600000

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PCRFB_SYNC_RST 3'h0

`endif

/* pcrfb_phy_model.sv */
// Purpose: Far side: recovered core clock and PHY cadence strobe
// Assumes: mclk stands for the faster PHY datapath clock
// Notes:   Cadence gaps vary from prompt to slow
`timescale 1ns/1ns
module pcrfb_phy_model (
    input wire logic mclk,
    input wire logic cadEn,
    output logic coreClk,
    output logic txCadence
);
    logic [2:0] gap_r = 3'h0;
    // Core rate clock, 125 ns, far slower than mclk, edges kept off mclk edges
    initial begin
        coreClk = 1'h0;
        #2;
        forever begin
            #62 coreClk = 1'h1;
            #63 coreClk = 1'h0;
        end
    end
    // One-cycle strobes with a random gap
    always @(posedge mclk) begin
        txCadence <= cadEn && gap_r == 3'h0;
        gap_r <= (gap_r == 3'h0) ? 3'($urandom_range(4, 0)) : gap_r - 3'h1;
    end
endmodule

/* pcrfb_pkg.sv */
// Purpose: Shared types of the PHY to core rate bridge
// Assumes: pcrfb_cfg.svh holds the numbers
// Notes:   Types only
`include "pcrfb_cfg.svh"
package pcrfb_pkg;

    // ------------------------------------------------------------
    // Data rate selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PCRFB_RATE_HD,
        PCRFB_RATE_3G,
        PCRFB_RATE_12G
    } pcrfb_rate_t;

    // ------------------------------------------------------------
    // Word types
    // ------------------------------------------------------------
    typedef logic [`PCRFB_PHY_WIDTH-1:0] pcrfb_phy_t;
    typedef logic [`PCRFB_DATA_WIDTH-1:0] pcrfb_data_t;

endpackage

/* testbench.sv */
// Purpose: Self-checking bench of the rate bridge
// Assumes: pcrfb_phy_model supplies coreClk and txCadence
// Notes:   Random words, fill to refusal, overflow and underrun
`timescale 1ns/1ns
module testbench
    import pcrfb_pkg::*;
;
    logic mclk = 1'h0;
    logic srst = 1'h1;
    logic cadEn = 1'h0;
    logic rxChk = 1'h0;
    logic txCoreValid = 1'h0;
    logic coreClk, txCadence, rxCoreValid_r, rxOverflow_r, txCoreReady_r, txUnderrun_r;
    logic [39:0] rxPhyData = 40'h0;
    logic [39:0] txPhyData_r;
    pcrfb_data_t txCoreData = 20'h0;
    pcrfb_data_t rxCoreData_r, d;
    pcrfb_data_t rxQ[$], txQ[$];
    int failures = 0;
    int comparisons = 0;
    int mclkCnt = 0;
    int lastRise = 0;
    int corePeriod = 0;

    always #5 mclk = ~mclk;

    // Counts datapath cycles per core clock period
    always @(posedge mclk) mclkCnt <= mclkCnt + 1;
    always @(posedge coreClk) begin
        corePeriod = mclkCnt - lastRise;
        lastRise = mclkCnt;
    end

    pcrfb_bridge i_pcrfb_bridge (.mclk(mclk), .srst(srst), .coreClk(coreClk),
        .rxPhyData(rxPhyData), .rxCoreData_r(rxCoreData_r), .rxCoreValid_r(rxCoreValid_r),
        .rxOverflow_r(rxOverflow_r), .txCoreData(txCoreData), .txCoreValid(txCoreValid),
        .txCoreReady_r(txCoreReady_r), .txCadence(txCadence), .txPhyData_r(txPhyData_r),
        .txUnderrun_r(txUnderrun_r));
    pcrfb_phy_model i_pcrfb_phy_model (.mclk(mclk), .cadEn(cadEn), .coreClk(coreClk),
        .txCadence(txCadence));

    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Drives one random PHY word; one with push set is expected at the core
    task automatic rxWord(input logic q, input logic push);
        logic [39:0] w;
        w = {8'($urandom()), 32'($urandom())};
        w[38] = q;
        if (push) rxQ.push_back(w[19:0]);
        @(posedge mclk);
        rxPhyData <= w;
    endtask

    // Core side looks once per period after the output settles
    always @(posedge coreClk) begin
        repeat (6) @(posedge mclk);
        if (rxChk && rxCoreValid_r === 1'h1 && rxQ.size() > 0) begin
            check("rxCoreData", 40'(rxCoreData_r), 40'(rxQ.pop_front()));
        end
    end
    // Each transmit qualifier carries the next core word while any are queued
    always @(posedge mclk) begin
        if (txPhyData_r[38] === 1'h1 && txQ.size() > 0) begin
            check("txPhyData", txPhyData_r, {20'h40000, txQ.pop_front()});
        end
    end

    initial begin
        void'($urandom(32'h549E26D1));
        repeat (16) @(posedge mclk);
        srst <= 1'h0;
        rxChk <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            d[0] = 1'($urandom());
            rxWord(d[0], d[0]);
        end
        rxWord(1'h0, 1'h0);
        for (int i = 0; i < 300 && rxQ.size() > 0; i++) @(posedge mclk);
        check("rxLeft", 40'(rxQ.size()), 40'h0);
        check("rxOverflow", 40'(rxOverflow_r), 40'h0);
        rxChk <= 1'h0;
        for (int i = 0; i < 12; i++) rxWord(1'h1, 1'h0);
        rxWord(1'h0, 1'h0);
        repeat (2) @(posedge mclk);
        check("rxOverflow", 40'(rxOverflow_r), 40'h1);
        // Nine words, one per core period; the ninth meets a full FIFO
        for (int i = 0; i < 9; i++) begin
            @(posedge coreClk);
            @(posedge mclk);
            d = 20'($urandom());
            txCoreData <= d;
            txCoreValid <= 1'h1;
            if (i < 8) txQ.push_back(d);
        end
        @(posedge coreClk);
        @(posedge mclk);
        txCoreValid <= 1'h0;
        check("txCoreReady", 40'(txCoreReady_r), 40'h0);
        cadEn <= 1'h1;
        for (int i = 0; i < 400 && txQ.size() > 0; i++) @(posedge mclk);
        repeat (20) @(posedge mclk);
        check("txLeft", 40'(txQ.size()), 40'h0);
        check("txUnderrun", 40'(txUnderrun_r), 40'h1);
        check("txCoreReady", 40'(txCoreReady_r), 40'h1);
        // Datapath clock runs at least twice the core rate
        check("corePeriod", 40'(corePeriod >= 2), 40'h1);
        give_verdict();
    end

    // Cuts a hang short
    initial begin
        repeat (50000) @(posedge mclk);
        failures++;
        give_verdict();
    end
endmodule
